// >>> shared/acps_pkg.sv
`default_nettype none
package acps_pkg;
    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int unsigned ACPS_VW        = 16;
    localparam int unsigned ACPS_CW        = 16;
    localparam int unsigned ACPS_SLOTS     = 9;
    localparam int unsigned ACPS_NALARM    = 7;
    localparam logic [3:0]  ACPS_SLOT_MIN  = 4'h1;
    localparam logic [3:0]  ACPS_SLOT_MAX  = 4'h9;
    // ------------------------------------------------------------
    // alarm indices
    // ------------------------------------------------------------
    localparam int unsigned ACPS_AL_OV     = 0;
    localparam int unsigned ACPS_AL_OT     = 1;
    localparam int unsigned ACPS_AL_OP     = 2;
    localparam int unsigned ACPS_AL_OC     = 3;
    localparam int unsigned ACPS_AL_PF     = 4;
    localparam int unsigned ACPS_AL_SB     = 5;
    localparam int unsigned ACPS_AL_FO     = 6;
    // ------------------------------------------------------------
    // register offsets (byte addr, word index = byte addr / 4)
    // ------------------------------------------------------------
    localparam logic [7:0]  ACPS_A_CNT0    = 8'h00;
    localparam logic [7:0]  ACPS_A_QCOND   = 8'h20;
    localparam logic [7:0]  ACPS_A_VSET    = 8'h24;
    localparam logic [7:0]  ACPS_A_ISET    = 8'h28;
    localparam logic [7:0]  ACPS_A_OVTH    = 8'h2C;
    localparam logic [7:0]  ACPS_A_OCTH    = 8'h30;
    localparam logic [7:0]  ACPS_A_CMD     = 8'h34;
    localparam logic [7:0]  ACPS_A_RESULT  = 8'h38;
    localparam logic [7:0]  ACPS_A_CTRL    = 8'h3C;
    localparam logic [7:0]  ACPS_A_ISTAT   = 8'h40;
    localparam logic [7:0]  ACPS_A_ICLR    = 8'h44;
    localparam logic [7:0]  ACPS_A_IEN     = 8'h48;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned ACPS_Q_OT      = 3;
    localparam int unsigned ACPS_Q_REM     = 10;
    localparam int unsigned ACPS_Q_ON      = 11;
    localparam int unsigned ACPS_CTRL_ON   = 0;
    localparam int unsigned ACPS_CTRL_REM  = 1;
    localparam int unsigned ACPS_CTRL_OTOF = 2;
    localparam int unsigned ACPS_IRQ_W     = 4;
    localparam int unsigned ACPS_I_ALARM   = 0;
    localparam int unsigned ACPS_I_DONE    = 1;
    localparam int unsigned ACPS_I_REJ     = 2;
    localparam int unsigned ACPS_I_OT      = 3;
    // ------------------------------------------------------------
    // commands: cmd word = {slot[7:4], op[3:0]}
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ACPS_OP_SAVE   = 4'h1,
        ACPS_OP_RECALL = 4'h2,
        ACPS_OP_DELETE = 4'h3,
        ACPS_OP_VALID  = 4'h4
    } acps_op_e;
    localparam logic [ACPS_CW-1:0] ACPS_CNT_RST = 16'h0000;
    localparam logic [ACPS_VW-1:0] ACPS_VAL_RST = 16'h0000;
endpackage : acps_pkg
`default_nettype wire

// >>> shared/acps_slot_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acps_slot_if;
    logic       we;
    logic       wvld;
    logic [3:0] idx;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic       rvld;
    modport ctl (output we, wvld, idx, wdata, input rdata, rvld);
    modport mem (input we, wvld, idx, wdata, output rdata, rvld);
endinterface : acps_slot_if
`default_nettype wire

// >>> logic/acps_slot_store.sv
`timescale 1ns/1ps
`default_nettype none
// nine-slot preset storage, each slot carries a valid mark
module acps_slot_store (
    input  wire logic clk,
    input  wire logic rst_b,
    acps_slot_if.mem  sif
);
    import acps_pkg::*;

    typedef struct packed {
        logic [ACPS_SLOTS-1:0][63:0] data;
        logic [ACPS_SLOTS-1:0]       vld;
    } acps_store_s;

    acps_store_s st_q;
    acps_store_s st_d;

    always_comb begin
        st_d = st_q;
        if (sif.we) begin
            st_d.data[sif.idx] = sif.wdata;
            st_d.vld[sif.idx]  = sif.wvld;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // combinational read, index is range checked by the controller
    assign sif.rdata = st_q.data[sif.idx];
    assign sif.rvld  = st_q.vld[sif.idx];
endmodule : acps_slot_store
`default_nettype wire

// >>> logic/acps_top.sv
// Functional notes
// - one occurrence counter per alarm type, incremented on each alarm, holding at all ones
// - counters readable anytime, cleared by reset, cleared when read
// - separate counters for overvoltage, overtemperature, overpower, overcurrent, power fail
// - extra counters for share-bus failure and floating overvoltage alarms
// - questionable word bit 10 remote active, bit 11 output on
// - overtemperature alarm sets questionable bit 3, weight 8
// - optional variant: overtemperature clears output-on indication
// - nine slots; recall loads voltage, current, both thresholds into active values
// - save copies four active values into selected slot
// - preset commands executed only while output is off
// - delete zeroes the selected slot's values and sets its valid mark; slot stays writable
// - validity query returns 1 when slot stored correctly, else 0
// - overtemperature bit needs no acknowledge, follows the condition
`timescale 1ns/1ps
`default_nettype none
module acps_top
    import acps_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic [7:0]               addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic [31:0]                   rdata,
    input  wire logic [ACPS_NALARM-1:0]   alarm_pin,
    output logic                          irq,
    output logic                          out_on,
    output logic [ACPS_VW-1:0]            vset,
    output logic [ACPS_VW-1:0]            iset,
    output logic [ACPS_VW-1:0]            ovth,
    output logic [ACPS_VW-1:0]            octh
);
    import acps_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ACPS_NALARM-1:0]            s1;
        logic [ACPS_NALARM-1:0]            s2;
        logic [ACPS_NALARM-1:0]            prev;
        logic [ACPS_NALARM-1:0][ACPS_CW-1:0] cnt;
        logic [ACPS_VW-1:0]                vset;
        logic [ACPS_VW-1:0]                iset;
        logic [ACPS_VW-1:0]                ovth;
        logic [ACPS_VW-1:0]                octh;
        logic                              on;
        logic                              rem;
        logic                              otoff;
        logic [1:0]                        result;
        logic [ACPS_IRQ_W-1:0]             ist;
        logic [ACPS_IRQ_W-1:0]             ien;
        logic [31:0]                       rdata;
        logic                              irq;
    } acps_state_s;

    acps_state_s st_q;
    acps_state_s st_d;

    acps_slot_if sif ();

    acps_slot_store u_store (
        .clk   (clk),
        .rst_b (rst_b),
        .sif   (sif)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic slot_ok(input logic [3:0] s);
        slot_ok = (s >= ACPS_SLOT_MIN) && (s <= ACPS_SLOT_MAX);
    endfunction : slot_ok

    function automatic logic [ACPS_CW-1:0] sat_inc(input logic [ACPS_CW-1:0] c);
        sat_inc = (&c) ? c : c + 16'h0001;
    endfunction : sat_inc

    logic [3:0] cmd_slot;
    logic [3:0] cmd_op;
    logic       cmd_wr;
    logic [63:0] act_word;
    logic [3:0] cnt_idx;

    assign cmd_slot = wdata[7:4];
    assign cmd_op   = wdata[3:0];
    assign cmd_wr   = wr && (addr == ACPS_A_CMD);
    assign act_word = {st_q.vset, st_q.iset, st_q.ovth, st_q.octh};
    assign cnt_idx  = addr[5:2];

    // slot port driven from the command decode
    always_comb begin
        sif.idx   = 4'h0;
        sif.we    = 1'b0;
        sif.wvld  = 1'b0;
        sif.wdata = 64'h0000000000000000;
        if (cmd_wr && slot_ok(cmd_slot) && !st_q.on) begin
            sif.idx = cmd_slot - 4'h1;
            unique case (cmd_op)
                ACPS_OP_SAVE: begin
                    sif.we    = 1'b1;
                    sif.wvld  = 1'b1;
                    sif.wdata = act_word;
                end
                ACPS_OP_DELETE: begin
                    sif.we    = 1'b1;
                    sif.wvld  = 1'b1;
                    sif.wdata = 64'h0000000000000000;
                end
                default: begin
                    sif.we = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [ACPS_NALARM-1:0] rise;
        logic [ACPS_IRQ_W-1:0]  ev;
        logic                   ot_now;
        logic [15:0]            qcond;
        rise   = '0;
        ev     = '0;
        ot_now = 1'b0;
        qcond  = 16'h0000;
        st_d   = st_q;

        st_d.s1   = alarm_pin;
        st_d.s2   = st_q.s1;
        st_d.prev = st_q.s2;
        rise      = st_q.s2 & ~st_q.prev;
        ot_now    = st_q.s2[ACPS_AL_OT];

        // optional shutdown of output on overtemperature
        if (rise[ACPS_AL_OT] && st_q.otoff) begin
            st_d.on = 1'b0;
        end

        qcond[ACPS_Q_OT]  = ot_now;
        qcond[ACPS_Q_REM] = st_q.rem;
        qcond[ACPS_Q_ON]  = st_q.on;

        st_d.rdata = 32'h00000000;
        if (rd) begin
            if (addr < ACPS_A_QCOND && cnt_idx < 4'h7) begin
                st_d.rdata = {16'h0000, st_q.cnt[cnt_idx]};
                st_d.cnt[cnt_idx] = ACPS_CNT_RST;
            end else begin
                unique case (addr)
                    ACPS_A_QCOND:  st_d.rdata = {16'h0000, qcond};
                    ACPS_A_VSET:   st_d.rdata = {16'h0000, st_q.vset};
                    ACPS_A_ISET:   st_d.rdata = {16'h0000, st_q.iset};
                    ACPS_A_OVTH:   st_d.rdata = {16'h0000, st_q.ovth};
                    ACPS_A_OCTH:   st_d.rdata = {16'h0000, st_q.octh};
                    ACPS_A_RESULT: st_d.rdata = {30'h00000000, st_q.result};
                    ACPS_A_CTRL:   st_d.rdata = {29'h00000000, st_q.otoff, st_q.rem, st_q.on};
                    ACPS_A_ISTAT:  st_d.rdata = {28'h0000000, st_q.ist};
                    ACPS_A_IEN:    st_d.rdata = {28'h0000000, st_q.ien};
                    default:       st_d.rdata = 32'h00000000;
                endcase
            end
        end

        // counting after the read clear so a same-cycle alarm survives
        for (int i = 0; i < ACPS_NALARM; i++) begin
            if (rise[i]) begin
                st_d.cnt[i] = sat_inc(st_d.cnt[i]);
            end
        end

        if (wr) begin
            unique case (addr)
                ACPS_A_VSET: st_d.vset = wdata[15:0];
                ACPS_A_ISET: st_d.iset = wdata[15:0];
                ACPS_A_OVTH: st_d.ovth = wdata[15:0];
                ACPS_A_OCTH: st_d.octh = wdata[15:0];
                ACPS_A_CTRL: begin
                    st_d.on    = wdata[ACPS_CTRL_ON];
                    st_d.rem   = wdata[ACPS_CTRL_REM];
                    st_d.otoff = wdata[ACPS_CTRL_OTOF];
                end
                ACPS_A_ICLR: st_d.ist = st_q.ist & ~wdata[3:0];
                ACPS_A_IEN:  st_d.ien = wdata[3:0];
                default:     st_d.ien = st_q.ien;
            endcase
        end

        if (cmd_wr) begin
            if (!slot_ok(cmd_slot) || st_q.on) begin
                ev[ACPS_I_REJ] = 1'b1;
                st_d.result    = 2'h2;
            end else begin
                ev[ACPS_I_DONE] = 1'b1;
                st_d.result     = 2'h0;
                unique case (cmd_op)
                    ACPS_OP_RECALL: begin
                        st_d.vset = sif.rdata[63:48];
                        st_d.iset = sif.rdata[47:32];
                        st_d.ovth = sif.rdata[31:16];
                        st_d.octh = sif.rdata[15:0];
                    end
                    ACPS_OP_VALID: begin
                        st_d.result = {1'b0, sif.rvld};
                    end
                    ACPS_OP_SAVE, ACPS_OP_DELETE: begin
                        st_d.result = 2'h0;
                    end
                    default: begin
                        ev[ACPS_I_DONE] = 1'b0;
                        ev[ACPS_I_REJ]  = 1'b1;
                        st_d.result     = 2'h2;
                    end
                endcase
            end
        end

        ev[ACPS_I_ALARM] = |rise;
        ev[ACPS_I_OT]    = rise[ACPS_AL_OT];
        // set wins over a clear in the same cycle
        st_d.ist = st_d.ist | ev;
        st_d.irq = |(st_d.ist & st_d.ien);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata  = st_q.rdata;
    assign irq    = st_q.irq;
    assign out_on = st_q.on;
    assign vset   = st_q.vset;
    assign iset   = st_q.iset;
    assign ovth   = st_q.ovth;
    assign octh   = st_q.octh;
endmodule : acps_top
`default_nettype wire

// >>> tb/acps_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// remote host: one command per write strobe, n queries per read strobe, nothing held between them
module acps_host_model (
    input  wire logic        clk,
    input  wire logic [31:0] rdata,
    output logic [7:0]       addr,
    output logic [31:0]      wdata,
    output logic             wr,
    output logic             rd
);
    initial {addr, wdata, wr, rd} = '0;
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        // stale data is inverted so a late sample cannot pass by luck
        wdata <= ~d;
    endtask : put
    // n back-to-back reads of one place; d holds the last answer
    task automatic get(input logic [7:0] a, input int n, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        repeat (n) @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : get
endmodule : acps_host_model
`default_nettype wire

// >>> tb/acps_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module acps_top_asserts
    import acps_pkg::*;
(
    input wire logic                         clk,
    input wire logic                         rst_b,
    input wire logic [7:0]                   addr,
    input wire logic [31:0]                  wdata,
    input wire logic                         wr,
    input wire logic                         rd,
    input wire logic [31:0]                  rdata,
    input wire logic [acps_pkg::ACPS_NALARM-1:0] alarm_pin,
    input wire logic                         irq,
    input wire logic                         out_on,
    input wire logic [acps_pkg::ACPS_VW-1:0] vset,
    input wire logic [acps_pkg::ACPS_VW-1:0] iset,
    input wire logic [acps_pkg::ACPS_VW-1:0] ovth,
    input wire logic [acps_pkg::ACPS_VW-1:0] octh
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic [63:0] vals;
    logic        cmd;
    logic        bad_slot;
    assign vals     = {vset, iset, ovth, octh};
    assign cmd      = wr && addr == ACPS_A_CMD;
    assign bad_slot = wdata[7:4] < ACPS_SLOT_MIN || wdata[7:4] > ACPS_SLOT_MAX;
    // ------------------------------------------------------------
    // preset gating, status word, counter clear and output state
    // ------------------------------------------------------------
    chk_on_refuses: assert property (cmd && out_on |=> $stable(vals))
        else $error("preset command acted with output on");
    chk_slot_range: assert property (cmd && bad_slot |=> $stable(vals))
        else $error("bad slot number changed values");
    chk_vset_cause: assert property ($changed(vset) |-> $past(wr) &&
        ($past(addr) == ACPS_A_VSET || $past(addr) == ACPS_A_CMD)) else $error("voltage set value changed by itself");
    chk_qcond_on: assert property (rd && addr == ACPS_A_QCOND |=>
        rdata[ACPS_Q_ON] == $past(out_on) && rdata[9:4] == 6'h0) else $error("status word output bit wrong");
    chk_ot_shown: assert property (alarm_pin[ACPS_AL_OT] [*5] ##0 (rd && addr == ACPS_A_QCOND) |=> rdata[ACPS_Q_OT])
        else $error("overtemperature bit missing");
    chk_ot_gone: assert property ((!alarm_pin[ACPS_AL_OT]) [*5] ##0 (rd && addr == ACPS_A_QCOND) |=> !rdata[3])
        else $error("overtemperature bit stuck");
    chk_cnt_clear: assert property ((!alarm_pin[ACPS_AL_OV]) [*4] ##1 (rd && addr == ACPS_A_CNT0) ##1
        (rd && addr == ACPS_A_CNT0) |=> rdata == 32'h0) else $error("counter not cleared by read");
    chk_ctrl_on: assert property (wr && addr == ACPS_A_CTRL && !wdata[ACPS_CTRL_OTOF] |=>
        out_on == $past(wdata[ACPS_CTRL_ON])) else $error("output state not taken");
    cover property (cmd && out_on);
    cover property (irq);
    cover property ($fell(out_on) && !$past(wr));
endmodule : acps_top_asserts
bind acps_top acps_top_asserts acps_top_asserts_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .alarm_pin(alarm_pin), .irq(irq), .out_on(out_on), .vset(vset),
    .iset(iset), .ovth(ovth), .octh(octh));
`default_nettype wire

// >>> tb/tb_alarm_counter_preset_store.sv
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_counter_preset_store;
    import acps_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} acps_row_s;
    logic                   clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic [ACPS_NALARM-1:0] alarm_pin = '0;
    logic [7:0]             addr;
    logic [31:0]            wdata, rdata, got;
    logic                   wr, rd, irq, out_on;
    logic [ACPS_VW-1:0]     vset, iset, ovth, octh;
    int                     n_errors = 0, samples_checked = 0, cyc = 0;
    // host sequence: values first, then save, check, recall, validity query of unused slot 6
    acps_row_s rows [14] = '{
        '{1'b1, ACPS_A_VSET, 32'hA}, '{1'b1, ACPS_A_ISET, 32'h5}, '{1'b1, ACPS_A_OVTH, 32'hC},
        '{1'b1, ACPS_A_OCTH, 32'h16}, '{1'b1, ACPS_A_CMD, 32'h51}, '{1'b0, ACPS_A_RESULT, 32'h0},
        '{1'b1, ACPS_A_CMD, 32'h54}, '{1'b0, ACPS_A_RESULT, 32'h1}, '{1'b1, ACPS_A_VSET, 32'h1234},
        '{1'b1, ACPS_A_OCTH, 32'hFFFF}, '{1'b1, ACPS_A_CMD, 32'h52}, '{1'b0, ACPS_A_VSET, 32'hA},
        '{1'b0, ACPS_A_OCTH, 32'h16}, '{1'b1, ACPS_A_CMD, 32'h64}};
    always #4 clk = ~clk;
    acps_top acps_top_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .alarm_pin(alarm_pin), .irq(irq), .out_on(out_on), .vset(vset), .iset(iset), .ovth(ovth), .octh(octh));
    acps_host_model acps_host_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : check
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] g;
        if (w)
            acps_host_model_i.put(a, d);
        else begin
            acps_host_model_i.get(a, 1, g);
            check(g, d, "register read");
        end
    endtask : rw
    // levels are held long enough to cross the two-stage synchroniser
    task automatic pin(input int i, input logic v);
        @(posedge clk) alarm_pin[i] <= v;
        repeat (6) @(posedge clk);
    endtask : pin
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        check({vset, iset}, 32'h0, "reset values");
        check({ovth, octh} | {30'h0, irq, out_on}, 32'h0, "reset values");
        foreach (rows[k]) rw(rows[k].w, rows[k].a, rows[k].d);
        // look between edges so the value pins are settled
        @(negedge clk);
        check({vset, iset}, 32'h000A0005, "recalled values on pins");
        check({ovth, octh}, 32'h000C0016, "recalled limits on pins");
        rw(0, ACPS_A_RESULT, 32'h0);
        rw(1, ACPS_A_CMD, 32'h53);
        rw(1, ACPS_A_CMD, 32'h52);
        rw(0, ACPS_A_OVTH, 32'h0);
        for (int s = 1; s <= 9; s++) begin
            rw(1, ACPS_A_VSET, 32'(s));
            rw(1, ACPS_A_CMD, {24'h0, 4'(s), ACPS_OP_SAVE});
        end
        for (int s = 9; s >= 1; s--) begin
            rw(1, ACPS_A_CMD, {24'h0, 4'(s), ACPS_OP_RECALL});
            rw(0, ACPS_A_VSET, 32'(s));
        end
        rw(1, ACPS_A_CTRL, 32'h1);
        rw(1, ACPS_A_VSET, 32'h55);
        for (int op = 1; op <= 4; op++) begin
            rw(1, ACPS_A_CMD, {24'h0, 4'h2, 4'(op)});
            rw(0, ACPS_A_RESULT, 32'h2);
        end
        rw(1, ACPS_A_CTRL, 32'h0);
        rw(1, ACPS_A_CMD, 32'h22);
        rw(0, ACPS_A_VSET, 32'h2);
        rw(1, ACPS_A_CMD, 32'h02);
        rw(0, ACPS_A_RESULT, 32'h2);
        rw(1, ACPS_A_CMD, 32'h27);
        rw(0, ACPS_A_RESULT, 32'h2);
        rw(1, ACPS_A_CMD, 32'hA2);
        rw(0, ACPS_A_VSET, 32'h2);
        rw(1, ACPS_A_IEN, 32'h1);
        for (int i = 0; i < ACPS_NALARM; i++) begin
            repeat (2) begin
                pin(i, 1'b1);
                pin(i, 1'b0);
            end
            rw(0, ACPS_A_CNT0 + 8'(4 * i), 32'h2);
            rw(0, ACPS_A_CNT0 + 8'(4 * i), 32'h0);
        end
        check({31'h0, irq}, 32'h1, "interrupt raised");
        rw(0, ACPS_A_ISTAT, 32'hF);
        rw(1, ACPS_A_ICLR, 32'hF);
        rw(0, ACPS_A_ISTAT, 32'h0);
        rw(1, ACPS_A_IEN, 32'h0);
        pin(ACPS_AL_OV, 1'b1);
        pin(ACPS_AL_OV, 1'b0);
        check({31'h0, irq}, 32'h0, "interrupt masked");
        acps_host_model_i.get(ACPS_A_CNT0, 2, got);
        check(got, 32'h0, "second read of counter");
        rw(1, ACPS_A_CTRL, 32'h3);
        rw(0, ACPS_A_QCOND, 32'hC00);
        pin(ACPS_AL_OT, 1'b1);
        rw(0, ACPS_A_QCOND, 32'hC08);
        pin(ACPS_AL_OT, 1'b0);
        rw(0, ACPS_A_QCOND, 32'hC00);
        rw(1, ACPS_A_CTRL, 32'h7);
        pin(ACPS_AL_OT, 1'b1);
        check({31'h0, out_on}, 32'h0, "overtemperature shutdown");
        pin(ACPS_AL_OT, 1'b0);
        pin(ACPS_AL_PF, 1'b1);
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        check({vset, iset}, 32'h0, "values after reset");
        rst_b <= 1'b1;
        rw(0, ACPS_A_CNT0 + 8'h10, 32'h0);
        give_verdict();
    end
endmodule : tb_alarm_counter_preset_store
`default_nettype wire
